// ===== dv/dah_gate_chk.sv
// Port assertions for the debug gating block
`timescale 1ns/100ps
module dah_gate_chk
	import dah_pkg::*;
(
	input wire logic CLOCK, // Clock
	input wire logic RST_N, // Reset
	input wire logic LOCAL_RST_N, // Local reset
	input wire logic INVASIVE_PERMIT, // Permit
	input wire logic NONINVASIVE_PERMIT, // Permit
	input wire logic ACCESS_PORT_ENABLE, // Port on
	input wire logic EXT_RESTART_REQUEST, // Restart
	input wire dah_ap_req_s AP_REQ, // Request
	input wire logic HALTED, // Halted
	input wire logic WATCH_ENABLE, // Watch
	input wire logic AP_GRANT, // Grant
	input wire logic AP_ERROR // Error
);
	default clocking @(posedge CLOCK);
	endclocking
	default disable iff (!RST_N);
	wire private_peripheral_region = AP_REQ.addr[31:20] == 12'hE00;
	wire lock = !INVASIVE_PERMIT && !HALTED && ACCESS_PORT_ENABLE;
	property p_resp; AP_REQ.valid |=> AP_GRANT != AP_ERROR; endproperty
	a_resp: assert property (p_resp) else $error("port answer");
	property p_off; (!ACCESS_PORT_ENABLE) [*4] ##0 AP_REQ.valid |=> AP_ERROR; endproperty
	a_off: assert property (p_off) else $error("port off");
	property p_full; (INVASIVE_PERMIT && ACCESS_PORT_ENABLE) [*4] ##0 AP_REQ.valid |=> AP_GRANT; endproperty
	a_full: assert property (p_full) else $error("full access");
	property p_ppb; lock [*4] ##0 AP_REQ.valid && private_peripheral_region |=>
		AP_ERROR == ($past(AP_REQ.write) || !$past(NONINVASIVE_PERMIT)); endproperty
	a_ppb: assert property (p_ppb) else $error("region access");
	property p_rise; $rose(HALTED) |->
		$past(INVASIVE_PERMIT, 2) || $past(INVASIVE_PERMIT, 3) || $past(INVASIVE_PERMIT, 4); endproperty
	a_rise: assert property (p_rise) else $error("halt while barred");
	property p_rst; !LOCAL_RST_N |=> !HALTED; endproperty
	a_rst: assert property (p_rst) else $error("local reset");
	property p_go; HALTED && EXT_RESTART_REQUEST |-> ##[1:6] !HALTED; endproperty
	a_go: assert property (p_go) else $error("restart");
	property p_watch; (!INVASIVE_PERMIT && !NONINVASIVE_PERMIT && !HALTED) [*4] |=> !WATCH_ENABLE; endproperty
	a_watch: assert property (p_watch) else $error("watch on");
	cover property ($rose(HALTED));
	cover property (AP_REQ.valid ##1 AP_ERROR);
	cover property (!LOCAL_RST_N ##1 LOCAL_RST_N);
endmodule : dah_gate_chk

// ===== dv/dah_xtrig.sv
// Cross-trigger agent model raising halt and restart requests
`timescale 1ns/100ps
module dah_xtrig (
	input wire logic clk, // Core clock
	input wire logic rst_n, // Reset, low
	input wire logic halted, // Stopped indication
	input wire logic want_halt, // Bench asks for halt
	input wire logic want_restart, // Bench asks for restart
	output logic halt_rq, // Halt request
	output logic restart_rq // Restart request
);
	// Requests are raised only in the state that gives them meaning
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			{halt_rq, restart_rq} <= 2'b00;
		else
			{halt_rq, restart_rq} <= {want_halt && !halted, want_restart && halted};
	end
endmodule : dah_xtrig

// ===== dv/debug_auth_halt_gating_tb_top.sv
// Self-checking bench for the debug gating block
`timescale 1ns/100ps
`include "dah_defs.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; $display("mismatch %0t %h %h", $time, a, b); end end
module debug_auth_halt_gating_tb_top
	import dah_pkg::*;
;
	logic CLOCK = 1'b0, RST_N = 1'b0, LOCAL_RST_N = 1'b1, CLK_EN = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic INVASIVE_PERMIT = 1'b0, NONINVASIVE_PERMIT = 1'b0, ACCESS_PORT_ENABLE = 1'b0, want_h = 1'b0, want_r = 1'b0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = '0, PC_VALUE = 32'h0000_1000, PRDATA, rd;
	dah_core_evt_s CORE_EVT = '0;
	dah_ap_req_s AP_REQ = '0;
	logic EXT_HALT_REQUEST, EXT_RESTART_REQUEST, PREADY, PSLVERR, HALTED, HARD_FAULT, WATCH_ENABLE, STEP_IRQ_MASK;
	logic AP_GRANT, AP_ERROR, er;
	int fail_count = 0, samples_checked = 0;
	dah_gate dah_gate_inst (.*);
	dah_xtrig dah_xtrig_inst (.clk(CLOCK), .rst_n(RST_N), .halted(HALTED), .want_halt(want_h), .want_restart(want_r),
		.halt_rq(EXT_HALT_REQUEST), .restart_rq(EXT_RESTART_REQUEST));
	initial forever #12.5 CLOCK = ~CLOCK;
	task automatic close_out;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge CLOCK);
		{PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		do @(posedge CLOCK); while (PREADY !== 1'b1);
		{er, rd} = {PSLVERR, PRDATA};
		{PSEL, PENABLE} <= 2'b00;
	endtask : apb
	task automatic ap(input logic w, input logic [31:0] a, input logic e);
		@(posedge CLOCK);
		AP_REQ <= {1'b1, w, a};
		@(posedge CLOCK);
		AP_REQ <= '0;
		@(posedge CLOCK);
		`CHK({AP_ERROR, AP_GRANT}, {e, !e})
	endtask : ap
	task automatic wait_for(ref logic s, input logic v);
		for (int n = 0; n < 20 && s !== v; n++) @(posedge CLOCK);
		`CHK(s, v)
	endtask : wait_for
	task automatic t_ap;
		apb(1'b0, 12'h018, '0);
		`CHK(er, 1'b1)
		for (int i = 0; i < 8; i++) begin
			{INVASIVE_PERMIT, NONINVASIVE_PERMIT, ACCESS_PORT_ENABLE} <= i[2:0];
			repeat (5) @(posedge CLOCK);
			ap(1'b0, 32'hE000_E000, !i[0] || !(i[2] || i[1]));
			ap(1'b1, 32'hE00F_FFFC, !i[0] || !i[2]);
			ap(1'b1, 32'hE010_0000, !i[0]);
		end
	endtask : t_ap
	task automatic t_halt;
		apb(1'b1, `DAH_OFF_CTRL, 32'h0000_0001);
		want_h <= 1'b1;
		wait_for(HALTED, 1'b1);
		want_h <= 1'b0;
		apb(1'b0, `DAH_OFF_CTRL, '0);
		`CHK(rd[1:0], 2'b11)
		apb(1'b0, `DAH_OFF_AP, '0);
		`CHK(rd, 32'h0000_1000)
		apb(1'b1, `DAH_OFF_CTRL, 32'h0000_000F);
		apb(1'b1, `DAH_OFF_MON, 32'h0000_0004);
		repeat (2) @(posedge CLOCK);
		`CHK({STEP_IRQ_MASK, WATCH_ENABLE}, 2'b11)
		apb(1'b1, `DAH_OFF_EVT, 32'h0000_0010);
		apb(1'b0, `DAH_OFF_EVT, '0);
		`CHK(rd[4], 1'b0)
		want_r <= 1'b1;
		wait_for(HALTED, 1'b0);
		want_r <= 1'b0;
	endtask : t_halt
	task automatic t_lock;
		{INVASIVE_PERMIT, NONINVASIVE_PERMIT} <= 2'b00;
		repeat (4) @(posedge CLOCK);
		want_h <= 1'b1;
		repeat (12) @(posedge CLOCK);
		`CHK(HALTED, 1'b0)
		`CHK({STEP_IRQ_MASK, WATCH_ENABLE}, 2'b00)
		want_h <= 1'b0;
		CORE_EVT.sw_sw_breakpoint_instr <= 1'b1;
		@(posedge CLOCK);
		CORE_EVT.sw_sw_breakpoint_instr <= 1'b0;
		wait_for(HARD_FAULT, 1'b1);
		apb(1'b0, `DAH_OFF_AP, '0);
		`CHK(rd, 32'hFFFF_FFFF)
	endtask : t_lock
	task automatic t_lrst;
		INVASIVE_PERMIT <= 1'b1;
		want_h <= 1'b1;
		wait_for(HALTED, 1'b1);
		want_h <= 1'b0;
		apb(1'b1, `DAH_OFF_MON, 32'h0000_0002);
		repeat (4) @(posedge CLOCK);
		LOCAL_RST_N <= 1'b0;
		repeat (2) @(posedge CLOCK);
		`CHK(HALTED, 1'b0)
		LOCAL_RST_N <= 1'b1;
		wait_for(HALTED, 1'b1);
		apb(1'b0, `DAH_OFF_EVT, '0);
		`CHK(rd[3], 1'b1)
		want_r <= 1'b1;
		wait_for(HALTED, 1'b0);
	endtask : t_lrst
	initial begin
		repeat (5000) @(posedge CLOCK);
		fail_count++;
		close_out();
	end
	initial begin
		repeat (10) @(posedge CLOCK);
		RST_N <= 1'b1;
		t_ap();
		t_halt();
		t_lock();
		t_lrst();
		close_out();
	end
endmodule : debug_auth_halt_gating_tb_top
bind dah_gate dah_gate_chk dah_gate_chk_inst (.*);

// ===== rtl/dah_defs.svh
// Register offsets, field positions, reset values and constants for debug auth and halt gating
`ifndef DAH_DEFS_SVH
`define DAH_DEFS_SVH

`define DAH_OFF_CTRL 12'h000
`define DAH_OFF_MON 12'h004
`define DAH_OFF_EVT 12'h008
`define DAH_OFF_STAT 12'h00C
`define DAH_OFF_AP 12'h010
`define DAH_OFF_CMD 12'h014

`define DAH_CTRL_HALTEN 0
`define DAH_CTRL_HALT 1
`define DAH_CTRL_STEP 2
`define DAH_CTRL_MASK 3

`define DAH_MON_FAULTVC 0
`define DAH_MON_RESETVC 1
`define DAH_MON_WATCH 2

`define DAH_EVT_HALTED 0
`define DAH_EVT_SW_BREAKPOINT_INSTR 1
`define DAH_EVT_WATCH 2
`define DAH_EVT_VCATCH 3
`define DAH_EVT_EXT 4

`define DAH_CTRL_RST 4'h0
`define DAH_MON_RST 3'h0
`define DAH_EVT_RST 5'h00

`define DAH_PPB_BASE 32'hE000_0000
`define DAH_PPB_LAST 32'hE00F_FFFF
`define DAH_PCS_BLOCKED 32'hFFFF_FFFF

`endif

// ===== rtl/dah_gate.sv
// Debug authentication, halt request gating and access port permission check
//
// Contract
// - In Debug state behave as if invasive permit were high; the status nin_ok bit still reads nin | inv, not inv_eff.
// - Never enter Debug state with halting disabled or halting prohibited.
// - Halting prohibited when invasive permit low and not halted.
// - Prohibited: halt, step and mask bits act as zero.
// - Prohibited: external halt request and vector catches ignored.
// - Prohibited: software breakpoint escalates to hard fault or lockup.
// - Prohibited: hardware breakpoint escalates or is ignored.
// - Prohibited: watchpoint matches ignored.
// - Fully prohibited: watch unit enable treated as zero.
// - Fully prohibited: watch unit off, pc sample reads all ones.
// - Non-invasive allowed when either permit high.
// - Full permit or halted: access port reaches all memory.
// - Otherwise peripheral region blocked or read-only by non-invasive permit.
// - Blocked access port accesses answer with an error.
// - Access port enable low refuses every access.
// - External halt request outside Debug state halts and sets external flag.
// - External halt request ignored in Debug state.
// - Entering Debug state drives a halted indication output.
// - External restart in Debug state leaves Debug state.
// - External restart ignored outside Debug state.
// - Local reset leaves Debug state; control fields survive it.
// - Reset vector catch raises event leaving reset, halts if enabled.
// - Debug state entry sets the halt request bit.
// - Event flags set on halt or exception, cleared by writing one.
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "dah_defs.svh"

module dah_gate
	import dah_pkg::*;
(
	input wire logic CLOCK, // Core clock, 40 MHz
	input wire logic RST_N, // Power-on reset, async, low
	input wire logic LOCAL_RST_N, // Local reset, async, low
	input wire logic CLK_EN, // Freezes all state while low
	input wire logic INVASIVE_PERMIT, // Invasive debug permit pin
	input wire logic NONINVASIVE_PERMIT, // Non-invasive debug permit pin
	input wire logic EXT_HALT_REQUEST, // External halt request pin
	input wire logic EXT_RESTART_REQUEST, // External restart request pin
	input wire logic ACCESS_PORT_ENABLE, // Access port enable pin
	input wire dah_core_evt_s CORE_EVT, // Core debug event pulses
	input wire logic [31:0] PC_VALUE, // Current program counter
	input wire dah_ap_req_s AP_REQ, // Access port request
	input wire logic PSEL, // APB select
	input wire logic PENABLE, // APB enable
	input wire logic PWRITE, // APB direction
	input wire logic [11:0] PADDR, // APB byte address
	input wire logic [31:0] PWDATA, // APB write data
	output logic [31:0] PRDATA, // APB read data
	output logic PREADY, // APB ready
	output logic PSLVERR, // APB error
	output logic HALTED, // Debug state indication
	output logic HARD_FAULT, // Breakpoint escalation pulse
	output logic WATCH_ENABLE, // Effective watch unit enable
	output logic STEP_IRQ_MASK, // Effective interrupt mask while stepping
	output logic AP_GRANT, // Access port request allowed
	output logic AP_ERROR // Access port request refused
);

	// Synchroniser stages
	logic [4:0] pin_raw;
	logic [4:0] pin_meta_reg;
	logic [4:0] pin_sync_reg;
	logic inv;
	logic nin;
	logic hreq;
	logic rreq;
	logic apen;

	// Register state
	logic [3:0] ctrl_reg;
	logic [3:0] ctrl_next;
	logic [2:0] mon_reg;
	logic [2:0] mon_next;
	logic [4:0] evt_reg;
	logic [4:0] evt_next;
	logic [4:0] evt_set;

	// Debug state sequence
	dah_state_e state_reg;
	dah_state_e state_next;
	logic leaving_reset_reg;
	logic reset_exit;

	// Authentication and gating
	logic halted_s;
	logic inv_eff;
	logic prohibited;
	logic nin_ok;
	logic full_off;
	logic halt_en_eff;
	logic halt_eff;
	logic step_eff;
	logic mask_eff;

	// Debug events
	logic enter_halt;
	logic leave_halt;
	logic any_sw_breakpoint_instr;
	logic ext_evt;
	logic vc_evt;
	logic sw_breakpoint_instr_evt;
	logic watch_evt;

	// Bus and access port decode
	logic apb_wr;
	logic apb_rd;
	logic sel_ctrl;
	logic sel_mon;
	logic sel_evt;
	logic sel_stat;
	logic sel_pcs;
	logic ppb_hit;
	logic ap_block;
	logic clr_hit;

	// Pins from outside the clock domain, gathered for one synchroniser loop
	assign pin_raw = {ACCESS_PORT_ENABLE, EXT_RESTART_REQUEST, EXT_HALT_REQUEST, NONINVASIVE_PERMIT, INVASIVE_PERMIT};

	// Two flop synchroniser per pin; logic reads only the second stage
	for (genvar gi = 0; gi < 5; gi++) begin : g_sync
		always_ff @(posedge CLOCK or negedge RST_N) begin
			if (!RST_N) begin
				pin_meta_reg[gi] <= 1'b0;
				pin_sync_reg[gi] <= 1'b0;
			end else if (CLK_EN) begin
				pin_meta_reg[gi] <= pin_raw[gi];
				pin_sync_reg[gi] <= pin_meta_reg[gi];
			end
		end
	end

	assign inv = pin_sync_reg[0];
	assign nin = pin_sync_reg[1];
	assign hreq = pin_sync_reg[2];
	assign rreq = pin_sync_reg[3];
	assign apen = pin_sync_reg[4];

	// Authentication
	assign halted_s = (state_reg == DAH_HALTED);
	assign inv_eff = inv | halted_s;
	assign prohibited = !inv_eff;
	assign nin_ok = nin | inv;
	assign full_off = prohibited & !nin;

	assign halt_en_eff = ctrl_reg[`DAH_CTRL_HALTEN] & !prohibited;
	assign halt_eff = ctrl_reg[`DAH_CTRL_HALT] & halt_en_eff;
	assign step_eff = ctrl_reg[`DAH_CTRL_STEP] & halt_en_eff;
	assign mask_eff = ctrl_reg[`DAH_CTRL_MASK] & halt_en_eff;

	// Debug events, all gated by halting permission
	assign ext_evt = hreq & !halted_s & halt_en_eff;
	assign any_sw_breakpoint_instr = CORE_EVT.sw_sw_breakpoint_instr | CORE_EVT.hw_sw_breakpoint_instr;
	// A reset exit is either release of a reset here or the core reporting one
	assign reset_exit = leaving_reset_reg | CORE_EVT.reset_out;
	assign vc_evt = halt_en_eff & ((CORE_EVT.fault_vc & mon_reg[`DAH_MON_FAULTVC]) |
		(reset_exit & mon_reg[`DAH_MON_RESETVC]));
	assign sw_breakpoint_instr_evt = any_sw_breakpoint_instr & halt_en_eff;
	assign watch_evt = CORE_EVT.watch & WATCH_ENABLE & halt_en_eff;

	// Only a running core may halt; the restart state waits for the request to drop
	assign enter_halt = (state_reg == DAH_RUN) & (halt_eff | ext_evt | vc_evt | sw_breakpoint_instr_evt | watch_evt);
	assign leave_halt = halted_s & rreq;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			DAH_RUN: begin
				if (enter_halt) begin
					state_next = DAH_HALTED;
				end
			end
			DAH_HALTED: begin
				if (leave_halt) begin
					state_next = DAH_RESTART;
				end else if (ctrl_reg[`DAH_CTRL_HALTEN] && !ctrl_reg[`DAH_CTRL_HALT]) begin
					state_next = DAH_RESTART;
				end
			end
			DAH_RESTART: begin
				// Wait for the restart request to drop before re-arming
				if (!rreq) begin
					state_next = DAH_RUN;
				end
			end
			default: begin
				state_next = DAH_RUN;
			end
		endcase
	end

	// Debug state, cleared by either reset
	always_ff @(posedge CLOCK or negedge LOCAL_RST_N or negedge RST_N) begin
		if (!RST_N || !LOCAL_RST_N) begin
			state_reg <= DAH_RUN;
			leaving_reset_reg <= 1'b1;
			HALTED <= 1'b0;
		end else if (CLK_EN) begin
			state_reg <= state_next;
			leaving_reset_reg <= 1'b0;
			HALTED <= (state_next == DAH_HALTED);
		end
	end

	// Register decode, one select per mapped word
	always_comb begin
		sel_ctrl = 1'b0;
		sel_mon = 1'b0;
		sel_evt = 1'b0;
		sel_stat = 1'b0;
		sel_pcs = 1'b0;
		if (PADDR == `DAH_OFF_CTRL) begin
			sel_ctrl = 1'b1;
		end else if (PADDR == `DAH_OFF_MON) begin
			sel_mon = 1'b1;
		end else if (PADDR == `DAH_OFF_EVT) begin
			sel_evt = 1'b1;
		end else if (PADDR == `DAH_OFF_STAT) begin
			sel_stat = 1'b1;
		end else if (PADDR == `DAH_OFF_AP) begin
			sel_pcs = 1'b1;
		end
	end

	// Writes land at the access edge, reads are captured at the setup edge
	assign apb_wr = PSEL & PENABLE & PWRITE;
	assign apb_rd = PSEL & !PENABLE & !PWRITE;
	assign clr_hit = apb_wr & sel_evt;

	// Halt bit: a debug state entry wins over a register write in the same cycle
	always_comb begin
		ctrl_next = ctrl_reg;
		if (apb_wr && sel_ctrl) begin
			ctrl_next = PWDATA[3:0];
		end else if (leave_halt) begin
			ctrl_next[`DAH_CTRL_HALT] = 1'b0;
		end
		if (enter_halt) begin
			ctrl_next[`DAH_CTRL_HALT] = 1'b1;
		end
	end

	always_comb begin
		mon_next = mon_reg;
		if (apb_wr && sel_mon) begin
			mon_next = PWDATA[2:0];
		end
	end

	// Control fields survive local reset
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_reg <= `DAH_CTRL_RST;
		end else if (CLK_EN) begin
			ctrl_reg <= ctrl_next;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			mon_reg <= `DAH_MON_RST;
		end else if (CLK_EN) begin
			mon_reg <= mon_next;
		end
	end

	// Event flags: set by hardware, cleared by writing one; a set wins
	always_comb begin
		evt_set = 5'h00;
		evt_set[`DAH_EVT_HALTED] = enter_halt & halt_eff;
		evt_set[`DAH_EVT_SW_BREAKPOINT_INSTR] = sw_breakpoint_instr_evt | (any_sw_breakpoint_instr & !halt_en_eff);
		evt_set[`DAH_EVT_WATCH] = watch_evt;
		evt_set[`DAH_EVT_VCATCH] = vc_evt;
		evt_set[`DAH_EVT_EXT] = ext_evt;
	end

	localparam logic [4:0] EVT_RST = `DAH_EVT_RST;

	for (genvar gf = 0; gf < 5; gf++) begin : g_flag
		always_comb begin
			if (evt_set[gf]) begin
				evt_next[gf] = 1'b1;
			end else if (clr_hit && PWDATA[gf]) begin
				evt_next[gf] = 1'b0;
			end else begin
				evt_next[gf] = evt_reg[gf];
			end
		end

		always_ff @(posedge CLOCK or negedge RST_N) begin
			if (!RST_N) begin
				evt_reg[gf] <= EVT_RST[gf];
			end else if (CLK_EN) begin
				evt_reg[gf] <= evt_next[gf];
			end
		end
	end

	// APB answer: zero wait, registered one cycle after setup
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			PRDATA <= 32'h0000_0000;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
		end else if (CLK_EN) begin
			PREADY <= PSEL & !PENABLE;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h0000_0000;
			if (PSEL && !PENABLE) begin
				if (PADDR == `DAH_OFF_CTRL || PADDR == `DAH_OFF_MON || PADDR == `DAH_OFF_EVT ||
					PADDR == `DAH_OFF_STAT || PADDR == `DAH_OFF_AP) begin
					PSLVERR <= 1'b0;
				end else begin
					PSLVERR <= 1'b1;
				end
			end
			if (apb_rd) begin
				if (PADDR == `DAH_OFF_CTRL) begin
					PRDATA <= {28'h000_0000, ctrl_reg & {4{ctrl_reg[`DAH_CTRL_HALTEN]}}};
				end else if (PADDR == `DAH_OFF_MON) begin
					PRDATA <= {29'h0000_0000, mon_reg};
				end else if (PADDR == `DAH_OFF_EVT) begin
					PRDATA <= {27'h000_0000, evt_reg};
				end else if (PADDR == `DAH_OFF_STAT) begin
					PRDATA <= {28'h000_0000, nin_ok, prohibited, inv_eff, halted_s};
				end else if (PADDR == `DAH_OFF_AP) begin
					PRDATA <= full_off ? `DAH_PCS_BLOCKED : PC_VALUE;
				end
			end
		end
	end

	// Access port permission check
	assign ppb_hit = (AP_REQ.addr >= `DAH_PPB_BASE) && (AP_REQ.addr <= `DAH_PPB_LAST);
	assign ap_block = !apen |
		(!(inv | halted_s) & ppb_hit & (!nin_ok | AP_REQ.write));

	// Breakpoint escalation pulse
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			HARD_FAULT <= 1'b0;
		end else if (CLK_EN) begin
			HARD_FAULT <= any_sw_breakpoint_instr & !halt_en_eff;
		end
	end

	// Effective enables seen by the core and the watch unit
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			WATCH_ENABLE <= 1'b0;
			STEP_IRQ_MASK <= 1'b0;
		end else if (CLK_EN) begin
			WATCH_ENABLE <= mon_reg[`DAH_MON_WATCH] & !full_off;
			STEP_IRQ_MASK <= mask_eff & step_eff;
		end
	end

	// Access port answer, one cycle after the request
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			AP_GRANT <= 1'b0;
			AP_ERROR <= 1'b0;
		end else if (CLK_EN) begin
			AP_GRANT <= AP_REQ.valid & !ap_block;
			AP_ERROR <= AP_REQ.valid & ap_block;
		end
	end

endmodule : dah_gate

// ===== rtl/dah_pkg.sv
// Types shared by the debug auth and halt gating block
package dah_pkg;

	typedef enum logic [1:0] {
		DAH_RUN = 2'b00,
		DAH_HALTED = 2'b01,
		DAH_RESTART = 2'b10
	} dah_state_e;

	typedef struct packed {
		logic sw_sw_breakpoint_instr;
		logic hw_sw_breakpoint_instr;
		logic watch;
		logic fault_vc;
		logic reset_out;
	} dah_core_evt_s;

	typedef struct packed {
		logic valid;
		logic write;
		logic [31:0] addr;
	} dah_ap_req_s;

endpackage : dah_pkg
